//--- rtl/tmo_timer.sv
// Sixteen-bit timer/counter with APB register access
// Overview of operation
// - Atomic bit set gives one 16-bit access; clear gives two byte accesses.
// - In atomic mode high address reaches a buffer, never the true high byte.
// - In atomic mode reading low byte copies true high byte into the buffer.
// - In atomic mode writing low byte loads high byte from buffer together.
// - Low byte write clears prescaler; high byte write leaves it alone.
// - Prescale code 11,10,01,00 divides input by 8,4,2,1.
// - Internal source counts every instruction cycle, reference clock over four.
// - External source counts rising edges of pin or crystal oscillator.
// - External input synchronised when sync-disable clear, raw when set.
// - Sync-disable bit ignored while internal source selected.
// - Run bit set lets counter count, clear halts it.
// - Read-only status bit shows system clock taken from timer oscillator.
// - Oscillator enable bit powers the crystal oscillator, clear shuts it off.
// - Enabled oscillator keeps running in all power-managed modes.
// - While run bit set, both oscillator pins are inputs and port reads give zero.
// - Count wraps from all ones to zero, setting overflow flag; request gated.
// - Special event clears counter except asynchronous counting; write wins.
// - Special event clear never sets the overflow flag.
`timescale 1ns/100ps
`default_nettype none
`include "tmo_regs.svh"
module tmo_timer (
  // Clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  // APB slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // Count pins and oscillator
  input  wire logic        i_ext_count_pin,
  input  wire logic        i_crystal_clk,
  output logic             o_crystal_osc_enable,
  input  wire logic [1:0]  i_port_pins,
  output logic      [1:0]  o_port_read,
  output logic             o_pins_forced_input,
  // Core side
  input  wire logic        i_sysclk_from_timer_osc,
  input  wire logic        i_special_event,
  output logic             o_overflow_irq
);
  tmo_tick_if tk ();

  tmo_pkg::tmo_apb_st_t state_r;
  logic [7:0]  ctrl_r;
  logic [15:0] cnt_r;
  logic [7:0]  hbuf_r;
  logic        flag_r;
  logic        ien_r;
  logic        sysrun_r;
  logic [31:0] rd_val;
  logic        hit_ctrl;
  logic        hit_lo;
  logic        hit_hi;
  logic        hit_stat;
  logic        rd_phase;
  logic        done;
  logic        wr_lo;
  logic        wr_hi;
  logic        wr_ctrl;
  logic        wr_stat;
  logic        atomic;
  logic        async_cnt;
  logic        sev_clr;
  logic        inc_ok;
  logic        flag_nxt;

  tmo_tick_gen u_gen (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .tk        (tk)
  );

  assign atomic    = ctrl_r[`TMO_BIT_ATOMIC];
  assign async_cnt = ctrl_r[`TMO_BIT_SRC] & ctrl_r[`TMO_BIT_NOSYNC];

  assign tk.run      = ctrl_r[`TMO_BIT_RUN];
  assign tk.src_ext  = ctrl_r[`TMO_BIT_SRC];
  assign tk.sync_dis = ctrl_r[`TMO_BIT_NOSYNC];
  assign tk.ps_sel   = tmo_pkg::tmo_ps_t'(ctrl_r[`TMO_BIT_PS_HI:`TMO_BIT_PS_LO]);
  assign tk.ps_clr   = wr_lo;
  // Crystal takes over the count input once its oscillator is enabled
  assign tk.ext_in   = ctrl_r[`TMO_BIT_OSCEN] ? i_crystal_clk : i_ext_count_pin;

  assign hit_ctrl = (i_paddr == `TMO_OFF_CTRL);
  assign hit_lo   = (i_paddr == `TMO_OFF_CNT_LO);
  assign hit_hi   = (i_paddr == `TMO_OFF_CNT_HI);
  assign hit_stat = (i_paddr == `TMO_OFF_STAT);
  assign rd_phase = i_psel & i_penable & ~i_pwrite & (state_r == tmo_pkg::TMO_APB_IDLE);
  assign done     = i_psel & i_penable & o_pready;
  assign wr_lo    = done & i_pwrite & hit_lo;
  assign wr_hi    = done & i_pwrite & hit_hi;
  assign wr_ctrl  = done & i_pwrite & hit_ctrl;
  assign wr_stat  = done & i_pwrite & hit_stat;

  always_comb begin
    rd_val = 32'h0000_0000;
    if (hit_ctrl) begin
      rd_val[7:0] = {ctrl_r[7], sysrun_r, ctrl_r[5:0]};
    end else if (hit_lo) begin
      rd_val[7:0] = cnt_r[7:0];
    end else if (hit_hi) begin
      rd_val[7:0] = atomic ? hbuf_r : cnt_r[15:8];
    end else if (hit_stat) begin
      rd_val[`TMO_STAT_FLAG] = flag_r;
      rd_val[`TMO_STAT_IEN]  = ien_r;
    end
  end

  // One wait state so read data leaves a flop
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      state_r   <= tmo_pkg::TMO_APB_IDLE;
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0000_0000;
    end else begin
      case (state_r)
        tmo_pkg::TMO_APB_IDLE: begin
          if (i_psel && i_penable) begin
            state_r   <= tmo_pkg::TMO_APB_ACK;
            o_pready  <= 1'b1;
            o_pslverr <= ~(hit_ctrl | hit_lo | hit_hi | hit_stat);
            o_prdata  <= i_pwrite ? 32'h0000_0000 : rd_val;
          end
        end
        tmo_pkg::TMO_APB_ACK: begin
          state_r   <= tmo_pkg::TMO_APB_IDLE;
          o_pready  <= 1'b0;
          o_pslverr <= 1'b0;
        end
        default: begin
          state_r  <= tmo_pkg::TMO_APB_IDLE;
          o_pready <= 1'b0;
        end
      endcase
    end
  end

  // Status bit is read-only, so writes never land in bit 6
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      ctrl_r <= `TMO_CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_r <= i_pwdata[7:0] & ~(8'h01 << `TMO_BIT_SYSRUN);
    end
  end

  // Oscillator enable follows the control bit only; no low-power mode gates it
  assign o_crystal_osc_enable = ctrl_r[`TMO_BIT_OSCEN];

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      sysrun_r <= 1'b0;
    end else begin
      sysrun_r <= i_sysclk_from_timer_osc;
    end
  end

  // Buffer is snapped in the same cycle the low byte is sampled for read data
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      hbuf_r <= `TMO_BYTE_RESET;
    end else if (wr_hi && atomic) begin
      hbuf_r <= i_pwdata[7:0];
    end else if (rd_phase && hit_lo && atomic) begin
      hbuf_r <= cnt_r[15:8];
    end
  end

  // Asynchronous counting may miss the trigger in silicon; here it is simply ignored
  assign sev_clr = i_special_event & ~async_cnt;
  assign inc_ok  = tk.tick & ~wr_lo & ~(wr_hi & ~atomic) & ~sev_clr;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      cnt_r <= `TMO_CNT_RESET;
    end else if (wr_lo) begin
      cnt_r <= atomic ? {hbuf_r, i_pwdata[7:0]} : {cnt_r[15:8], i_pwdata[7:0]};
    end else if (wr_hi && !atomic) begin
      cnt_r[15:8] <= i_pwdata[7:0];
    end else if (sev_clr) begin
      cnt_r <= `TMO_CNT_RESET;
    end else if (tk.tick) begin
      cnt_r <= cnt_r + `TMO_CNT_ONE;
    end
  end

  // A new wrap beats a same-cycle software clear
  assign flag_nxt = (inc_ok & (cnt_r == `TMO_CNT_MAX)) |
                    (flag_r & ~(wr_stat & i_pwdata[`TMO_STAT_FLAG]));

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      flag_r <= 1'b0;
      ien_r  <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
      if (wr_stat) begin
        ien_r <= i_pwdata[`TMO_STAT_IEN];
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_overflow_irq <= 1'b0;
    end else begin
      o_overflow_irq <= flag_r & ien_r;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_port_read         <= `TMO_PIN_READ0;
      o_pins_forced_input <= 1'b0;
    end else begin
      o_port_read         <= ctrl_r[`TMO_BIT_RUN] ? `TMO_PIN_READ0 : i_port_pins;
      o_pins_forced_input <= ctrl_r[`TMO_BIT_RUN];
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  a_atomic_low_write: assert property (wr_lo && atomic
      |=> cnt_r == {$past(hbuf_r), $past(i_pwdata[7:0])}) else $error("atomic write did not load both bytes");
  a_low_read_buffer: assert property (rd_phase && hit_lo && atomic
      |=> hbuf_r == $past(cnt_r[15:8]) && o_prdata[7:0] == $past(cnt_r[7:0]))
      else $error("low byte read did not snap high byte");
  a_high_read_buffer: assert property (rd_phase && hit_hi && atomic
      |=> o_prdata[7:0] == $past(hbuf_r)) else $error("atomic high read did not return buffer");
  a_wrap_sets_flag: assert property (inc_ok && cnt_r == `TMO_CNT_MAX
      |=> (cnt_r == `TMO_CNT_RESET && flag_r) ##1 (o_overflow_irq == $past(ien_r)))
      else $error("wrap did not clear count and set flag");
  a_event_clears: assert property (i_special_event && !async_cnt && !wr_lo && !wr_hi
      |=> cnt_r == `TMO_CNT_RESET) else $error("special event did not clear counter");
  a_event_no_flag: assert property (i_special_event && !async_cnt && !flag_r
      |=> !flag_r) else $error("special event set overflow flag");
  a_halt_holds: assert property (!ctrl_r[`TMO_BIT_RUN] && !wr_lo && !wr_hi && !i_special_event
      |=> $stable(cnt_r)) else $error("halted counter moved");
  a_pins_read_zero: assert property (ctrl_r[`TMO_BIT_RUN]
      |=> o_port_read == `TMO_PIN_READ0 && o_pins_forced_input) else $error("pins not read as zero");
  a_status_read: assert property (rd_phase && hit_ctrl
      |=> o_prdata[`TMO_BIT_SYSRUN] == $past(i_sysclk_from_timer_osc, 2)) else $error("clock status bit wrong");

  // Flag and request
  a_flag_sticky: assert property (flag_r && !(wr_stat && i_pwdata[`TMO_STAT_FLAG])
      |=> flag_r)
      else $error("overflow flag dropped without clear");
  a_flag_clear: assert property (flag_r && wr_stat && i_pwdata[`TMO_STAT_FLAG]
      && !(inc_ok && cnt_r == `TMO_CNT_MAX) |=> !flag_r)
      else $error("overflow flag not cleared");
  a_irq_masked: assert property (!ien_r
      |=> !o_overflow_irq)
      else $error("masked overflow raised request");
  // Byte access paths and read-only status bit
  a_buffer_write: assert property (wr_hi && atomic && !tk.tick && !sev_clr
      |=> cnt_r == $past(cnt_r) && hbuf_r == $past(i_pwdata[7:0]))
      else $error("atomic high write reached true high byte");
  a_direct_high: assert property (wr_hi && !atomic
      |=> cnt_r[15:8] == $past(i_pwdata[7:0]))
      else $error("direct high write lost");
  a_status_ro: assert property (wr_ctrl
      |=> !ctrl_r[`TMO_BIT_SYSRUN])
      else $error("clock status bit became writable");
  // Special event
  a_async_ignores: assert property (i_special_event && async_cnt && !wr_lo && !wr_hi && !tk.tick
      |=> $stable(cnt_r))
      else $error("asynchronous counter cleared by event");
  a_write_wins: assert property (wr_lo && i_special_event && !atomic
      |=> cnt_r == {$past(cnt_r[15:8]), $past(i_pwdata[7:0])})
      else $error("event beat software write");
  // Bus answer
  a_ready_pulse: assert property (o_pready
      |=> !o_pready)
      else $error("ready held past one cycle");
  a_err_with_ready: assert property (o_pslverr
      |-> o_pready)
      else $error("error flagged without ready");

  c_wrap: cover property (inc_ok && cnt_r == `TMO_CNT_MAX);
  c_write_event: cover property (wr_lo && i_special_event);
  c_atomic_write: cover property (wr_lo && atomic);
  c_event_clear: cover property (sev_clr && cnt_r != `TMO_CNT_RESET);
  c_async_tick: cover property (tk.tick && async_cnt);
endmodule : tmo_timer
`default_nettype wire

//--- rtl/tmo_regs.svh
// Register offsets, field positions, reset values and counts for the sixteen-bit timer
`ifndef TMO_REGS_SVH
`define TMO_REGS_SVH
`define TMO_OFF_CTRL     12'h000
`define TMO_OFF_CNT_LO   12'h004
`define TMO_OFF_CNT_HI   12'h008
`define TMO_OFF_STAT     12'h00c
`define TMO_CTRL_RESET   8'h00
`define TMO_CNT_RESET    16'h0000
`define TMO_BYTE_RESET   8'h00
`define TMO_BIT_ATOMIC   7
`define TMO_BIT_SYSRUN   6
`define TMO_BIT_PS_HI    5
`define TMO_BIT_PS_LO    4
`define TMO_BIT_OSCEN    3
`define TMO_BIT_NOSYNC   2
`define TMO_BIT_SRC      1
`define TMO_BIT_RUN      0
`define TMO_STAT_FLAG    0
`define TMO_STAT_IEN     1
`define TMO_CNT_MAX      16'hffff
`define TMO_CNT_ONE      16'h0001
`define TMO_QTR_MAX      2'h3
`define TMO_QTR_ONE      2'h1
`define TMO_PS_ONE       3'h1
`define TMO_PS_LIM1      3'h0
`define TMO_PS_LIM2      3'h1
`define TMO_PS_LIM4      3'h3
`define TMO_PS_LIM8      3'h7
`define TMO_PIN_READ0    2'h0
`endif

//--- rtl/tmo_pkg.sv
// Types shared by the sixteen-bit timer modules
`default_nettype none
package tmo_pkg;
  typedef enum logic [1:0] {
    TMO_PS_DIV1 = 2'b00,
    TMO_PS_DIV2 = 2'b01,
    TMO_PS_DIV4 = 2'b10,
    TMO_PS_DIV8 = 2'b11
  } tmo_ps_t;

  typedef enum logic [0:0] {
    TMO_APB_IDLE = 1'b0,
    TMO_APB_ACK  = 1'b1
  } tmo_apb_st_t;
endpackage : tmo_pkg
`default_nettype wire

//--- rtl/tmo_tick_if.sv
// Configuration and count tick between timer control and tick generator
`timescale 1ns/100ps
`default_nettype none
interface tmo_tick_if;
  logic             run;
  logic             src_ext;
  logic             sync_dis;
  tmo_pkg::tmo_ps_t ps_sel;
  logic             ps_clr;
  logic             ext_in;
  logic             tick;

  modport ctl (output run, output src_ext, output sync_dis, output ps_sel, output ps_clr, output ext_in,
               input tick);
  modport gen (input run, input src_ext, input sync_dis, input ps_sel, input ps_clr, input ext_in,
               output tick);
endinterface : tmo_tick_if
`default_nettype wire

//--- rtl/tmo_tick_gen.sv
// Count source selection, synchroniser, edge detect and input prescaler
`timescale 1ns/100ps
`default_nettype none
`include "tmo_regs.svh"
module tmo_tick_gen (
  // Clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_rst,
  // Control side
  tmo_tick_if.gen   tk
);
  logic [1:0] qtr_r;
  logic       sync1_r;
  logic       sync2_r;
  logic       sync3_r;
  logic       raw_prev_r;
  logic [2:0] ps_r;
  logic [2:0] ps_lim;
  logic       inst_tick;
  logic       src_pulse;

  // Instruction cycle is one in four reference clocks
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      qtr_r <= 2'h0;
    end else begin
      qtr_r <= qtr_r + `TMO_QTR_ONE;
    end
  end
  assign inst_tick = (qtr_r == `TMO_QTR_MAX);

  // Two-stage synchroniser, third flop only for edge detect
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      sync3_r <= 1'b0;
    end else begin
      sync1_r <= tk.ext_in;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // Unsynchronised path sees the pin two cycles earlier, at metastability risk
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      raw_prev_r <= 1'b0;
    end else begin
      raw_prev_r <= tk.ext_in;
    end
  end

  always_comb begin
    if (!tk.src_ext) begin
      src_pulse = inst_tick;
    end else if (tk.sync_dis) begin
      src_pulse = tk.ext_in & ~raw_prev_r;
    end else begin
      src_pulse = sync2_r & ~sync3_r;
    end
  end

  always_comb begin
    case (tk.ps_sel)
      tmo_pkg::TMO_PS_DIV1: ps_lim = `TMO_PS_LIM1;
      tmo_pkg::TMO_PS_DIV2: ps_lim = `TMO_PS_LIM2;
      tmo_pkg::TMO_PS_DIV4: ps_lim = `TMO_PS_LIM4;
      tmo_pkg::TMO_PS_DIV8: ps_lim = `TMO_PS_LIM8;
      default:              ps_lim = `TMO_PS_LIM1;
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst || tk.ps_clr) begin
      ps_r <= 3'h0;
    end else if (tk.run && src_pulse) begin
      ps_r <= (ps_r >= ps_lim) ? 3'h0 : ps_r + `TMO_PS_ONE;
    end
  end

  assign tk.tick = tk.run & src_pulse & (ps_r >= ps_lim) & ~tk.ps_clr;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  a_int_rate: assert property (tk.tick && !tk.src_ext && tk.ps_sel == tmo_pkg::TMO_PS_DIV1
      |=> !tk.tick[*3]) else $error("internal tick faster than one in four clocks");
  a_sync_edge: assert property (tk.tick && tk.src_ext && !tk.sync_dis
      |-> $past(tk.ext_in, 2) && !$past(tk.ext_in, 3)) else $error("synchronised tick without delayed edge");
  a_unsync_edge: assert property (tk.tick && tk.src_ext && tk.sync_dis
      |-> tk.ext_in && !$past(tk.ext_in)) else $error("unsynchronised tick without pin edge");
  a_presc_div8: assert property (tk.tick && !tk.src_ext && tk.ps_sel == tmo_pkg::TMO_PS_DIV8
      |=> (!tk.tick)[*8] ##1 (!tk.tick)[*8] ##1 (!tk.tick)[*8] ##1 (!tk.tick)[*7])
      else $error("divide by eight ticked early");
endmodule : tmo_tick_gen
`default_nettype wire

//--- verification/tmo_core_model.sv
// Processor core model: APB master issuing register accesses to the timer
`timescale 1ns/100ps
`default_nettype none
module tmo_core_model (
  // Clock
  input  wire logic        i_ref_clk,
  // APB master
  output logic             o_psel,
  output logic             o_penable,
  output logic             o_pwrite,
  output logic      [11:0] o_paddr,
  output logic      [31:0] o_pwdata,
  input  wire logic [31:0] i_prdata,
  input  wire logic        i_pready,
  input  wire logic        i_pslverr
);
  initial begin
    o_psel = 1'b0;
    o_penable = 1'b0;
    o_pwrite = 1'b0;
    o_paddr = 12'h000;
    o_pwdata = 32'h0000_0000;
  end

  // One transfer; ok stays low if the slave never answers within the bound
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err, output logic ok);
    int n;
    n = 0;
    @(posedge i_ref_clk);
    o_psel   <= 1'b1;
    o_pwrite <= wr;
    o_paddr  <= a;
    o_pwdata <= d;
    @(posedge i_ref_clk);
    o_penable <= 1'b1;
    @(posedge i_ref_clk);
    while (i_pready !== 1'b1 && n < 20) begin
      @(posedge i_ref_clk);
      n++;
    end
    q   = i_prdata;
    err = i_pslverr;
    ok  = (i_pready === 1'b1);
    o_psel    <= 1'b0;
    o_penable <= 1'b0;
  endtask : xfer
endmodule : tmo_core_model
`default_nettype wire

//--- verification/timer1_sixteen_bit_counter_test.sv
// Self-checking bench for the sixteen-bit timer
`timescale 1ns/100ps
`default_nettype none
`include "tmo_regs.svh"
module timer1_sixteen_bit_counter_test;
  localparam logic [11:0] a_ctl = `TMO_OFF_CTRL;
  localparam logic [11:0] a_lo  = `TMO_OFF_CNT_LO;
  localparam logic [11:0] a_hi  = `TMO_OFF_CNT_HI;
  localparam logic [11:0] a_st  = `TMO_OFF_STAT;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr;
  logic        osc_en, forced, irq, sysclk, sev, perr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [1:0]  drv, pins, port_rd;
  logic [7:0]  hb;
  int          failures, n_compared, seed, n, k;

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  tmo_core_model core (.i_ref_clk(clk), .o_psel(psel), .o_penable(penable), .o_pwrite(pwrite),
    .o_paddr(paddr), .o_pwdata(pwdata), .i_prdata(prdata), .i_pready(pready), .i_pslverr(pslverr));

  tmo_timer dut (.i_ref_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_ext_count_pin(drv[0]), .i_crystal_clk(drv[1]), .o_crystal_osc_enable(osc_en),
    .i_port_pins(pins), .o_port_read(port_rd), .o_pins_forced_input(forced),
    .i_sysclk_from_timer_osc(sysclk), .i_special_event(sev), .o_overflow_irq(irq));

  task automatic print_verdict;
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic acc(input logic wr, input logic [11:0] a, input logic [31:0] d);
    logic ok;
    core.xfer(wr, a, d, q, perr, ok);
    if (!ok) begin
      failures++;
      $display("wrong value at %0t: no answer from slave", $time);
      print_verdict();
    end
  endtask : acc

  // Counts expected on the internal source: one per four clocks, then the prescaler
  function automatic int exp_cnt(input logic [1:0] ps, input int cyc);
    return cyc / (4 << ps);
  endfunction : exp_cnt

  // Rising edges on the pin (bit 0) or crystal (bit 1), slow enough for the synchroniser
  task automatic pulses(input int cnt, input logic [1:0] m);
    repeat (cnt) begin
      drv <= m;
      repeat (4) @(posedge clk);
      drv <= 2'b00;
      repeat (4) @(posedge clk);
    end
  endtask : pulses

  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    $display("wrong value at %0t: run did not finish", $time);
    print_verdict();
  end

  initial begin
    seed = 32'ha82b;
    failures = 0;
    n_compared = 0;
    rst = 1'b1;
    drv = 2'b00;
    pins = 2'b00;
    sysclk = 1'b0;
    sev = 1'b0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (k = 0; k < 4; k++) begin
      acc(1'b0, 12'(k * 4), 32'h0);
      chk(q, 32'h0, "reset value");
    end
    acc(1'b0, 12'h010, 32'h0);
    chk({q[31:1], perr}, 32'h1, "unmapped read");
    $display("test reset done");
    // Every prescale code; the sync bit is random since it must not matter here
    for (k = 0; k < 4; k++) begin
      acc(1'b1, a_ctl, {26'h0, k[1:0], 1'b0, 1'($random(seed)), 2'b01});
      acc(1'b1, a_hi, 32'h0);
      acc(1'b1, a_lo, 32'h0);
      repeat (640) @(posedge clk);
      acc(1'b1, a_ctl, 32'h0);
      acc(1'b0, a_lo, 32'h0);
      n = int'(q[7:0]);
      acc(1'b0, a_hi, 32'h0);
      n = n + 256 * int'(q[7:0]);
      // One count of slack for the free-running quarter phase
      chk(32'(n >= exp_cnt(k[1:0], 643) - 1 && n <= exp_cnt(k[1:0], 643) + 1), 32'h1, "prescaled count");
    end
    $display("test prescaler done");
    pins <= 2'($random(seed));
    acc(1'b0, a_lo, 32'h0);
    n = int'(q);
    repeat (100) @(posedge clk);
    acc(1'b0, a_lo, 32'h0);
    chk(q, 32'(n), "halted count");
    chk({port_rd, forced}, {pins, 1'b0}, "idle port read");
    acc(1'b1, a_hi, 32'hff);
    acc(1'b1, a_lo, 32'hfe);
    acc(1'b1, a_ctl, 32'h01);
    repeat (3) @(posedge clk);
    chk({port_rd, forced}, 3'b001, "running port read");
    repeat (17) @(posedge clk);
    acc(1'b1, a_ctl, 32'h0);
    acc(1'b0, a_st, 32'h0);
    chk(q, 32'h1, "overflow flag");
    chk(32'(irq), 32'h0, "masked request");
    acc(1'b1, a_st, 32'h2);
    repeat (3) @(posedge clk);
    chk(32'(irq), 32'h1, "enabled request");
    acc(1'b1, a_st, 32'h3);
    repeat (3) @(posedge clk);
    chk(32'(irq), 32'h0, "cleared request");
    @(posedge clk);
    sev <= 1'b1;
    @(posedge clk);
    sev <= 1'b0;
    acc(1'b0, a_lo, 32'h0);
    chk(q, 32'h0, "event clears count");
    acc(1'b0, a_st, 32'h0);
    chk(q, 32'h2, "event leaves flag");
    @(posedge clk);
    sev <= 1'b1;
    acc(1'b1, a_lo, 32'h5a);
    sev <= 1'b0;
    acc(1'b0, a_lo, 32'h0);
    chk(q, 32'h5a, "write beats event");
    acc(1'b1, a_ctl, 32'h06);
    @(posedge clk);
    sev <= 1'b1;
    @(posedge clk);
    sev <= 1'b0;
    acc(1'b0, a_lo, 32'h0);
    chk(q, 32'h5a, "asynchronous count ignores event");
    $display("test overflow done");
    hb = 8'($random(seed)) | 8'h80;
    acc(1'b1, a_ctl, 32'h80);
    acc(1'b1, a_hi, {24'h0, hb});
    acc(1'b1, a_lo, 32'h34);
    acc(1'b1, a_hi, 32'h56);
    acc(1'b1, a_ctl, 32'h0);
    acc(1'b0, a_hi, 32'h0);
    chk(q, {24'h0, hb}, "true high byte");
    acc(1'b1, a_ctl, 32'h80);
    acc(1'b0, a_lo, 32'h0);
    chk(q, 32'h34, "atomic low read");
    acc(1'b0, a_hi, 32'h0);
    chk(q, {24'h0, hb}, "snapped high byte");
    acc(1'b1, a_ctl, 32'h0);
    acc(1'b1, a_hi, 32'h77);
    acc(1'b0, a_hi, 32'h0);
    chk(q, 32'h77, "direct high byte");
    $display("test atomic done");
    for (k = 0; k < 3; k++) begin
      acc(1'b1, a_ctl, (k == 2) ? 32'h08 : 32'h0);
      // Crystal start-up delay before relying on it
      if (k == 2) repeat (50) @(posedge clk);
      chk(32'(osc_en), 32'(k == 2), "oscillator enable");
      acc(1'b1, a_lo, 32'h0);
      acc(1'b1, a_ctl, (k == 2) ? 32'h0b : 32'(3 + 4 * k));
      n = 1 + ($random(seed) & 7);
      pulses(n, (k == 2) ? 2'b10 : 2'b01);
      repeat (8) @(posedge clk);
      acc(1'b1, a_ctl, 32'h0);
      acc(1'b0, a_lo, 32'h0);
      chk(q, 32'(n), "external count");
    end
    $display("test external done");
    sysclk <= 1'b1;
    repeat (3) @(posedge clk);
    acc(1'b0, a_ctl, 32'h0);
    chk(q, 32'h40, "clock status set");
    sysclk <= 1'b0;
    acc(1'b1, a_ctl, 32'h40);
    acc(1'b0, a_ctl, 32'h0);
    chk(q, 32'h0, "clock status read-only");
    $display("test status done");
    print_verdict();
  end
endmodule : timer1_sixteen_bit_counter_test
`default_nettype wire
